// *** rtl/bbc_pkg.sv ***
// shared constants and types for the bit, branch and call executor
package bbc_pkg;
    // widths
    localparam int PC_W = 15;
    localparam int IW = 14;
    localparam int DW = 8;
    localparam int FA_W = 7;
    localparam int BI_W = 3;
    localparam int BRA_W = 9;
    localparam int CALL_W = 11;
    localparam int PL_W = 7;
    localparam int PAGE_W = 4;
    // field positions in the instruction word and in the page latch
    localparam int F_LSB = 0;
    localparam int BIT_LSB = 7;
    localparam int BRA_LSB = 0;
    localparam int CALL_LSB = 0;
    localparam int PAGE_LSB = 3;
    // opcode match masks and values
    localparam logic [13:0] OPM_BIT = 14'h3C00;
    localparam logic [13:0] OPV_BIT_CLEAR = 14'h1000;
    localparam logic [13:0] OPV_BIT_SET = 14'h1400;
    localparam logic [13:0] OPV_SKIP_LOW = 14'h1800;
    localparam logic [13:0] OPV_SKIP_HIGH = 14'h1C00;
    localparam logic [13:0] OPM_RBRANCH = 14'h3E00;
    localparam logic [13:0] OPV_RBRANCH = 14'h3200;
    localparam logic [13:0] OPM_WBRANCH = 14'h3FFF;
    localparam logic [13:0] OPV_WBRANCH = 14'h000B;
    localparam logic [13:0] OPM_CALL = 14'h3800;
    localparam logic [13:0] OPV_CALL = 14'h2000;
    // reset values
    localparam logic [14:0] PC_RST = 15'h0000;
    localparam logic [6:0] FA_RST = 7'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    typedef enum logic [0:0] {
        BBC_ST_EXEC = 1'b0,
        BBC_ST_DISCARD = 1'b1
    } bbc_state_t;
endpackage : bbc_pkg

// *** rtl/bbc_dec_if.sv ***
// decoded instruction fields between decoder and executor
`timescale 1ns/100ps
`default_nettype none
interface bbc_dec_if;
    logic [13:0] instr;
    logic is_bit_clear;
    logic is_bit_set;
    logic is_skip_low;
    logic is_skip_high;
    logic is_rbranch;
    logic is_wbranch;
    logic is_call;
    logic [6:0] f_addr;
    logic [2:0] bit_idx;
    logic [8:0] bra_off;
    logic [10:0] call_k;
    modport dec (input instr, output is_bit_clear, is_bit_set, is_skip_low, is_skip_high,
                 is_rbranch, is_wbranch, is_call, f_addr, bit_idx, bra_off, call_k);
    modport exe (output instr, input is_bit_clear, is_bit_set, is_skip_low, is_skip_high,
                 is_rbranch, is_wbranch, is_call, f_addr, bit_idx, bra_off, call_k);
endinterface : bbc_dec_if
`default_nettype wire

// *** rtl/bbc_decode.sv ***
// opcode decoder for the bit, branch and call group
`timescale 1ns/100ps
`default_nettype none
module bbc_decode (
    bbc_dec_if.dec dif
);
    function automatic logic op_hit(input logic [13:0] w, input logic [13:0] m,
                                    input logic [13:0] v);
        op_hit = ((w & m) == v);
    endfunction : op_hit

    assign dif.is_bit_clear = op_hit(dif.instr, bbc_pkg::OPM_BIT, bbc_pkg::OPV_BIT_CLEAR);
    assign dif.is_bit_set = op_hit(dif.instr, bbc_pkg::OPM_BIT, bbc_pkg::OPV_BIT_SET);
    assign dif.is_skip_low = op_hit(dif.instr, bbc_pkg::OPM_BIT, bbc_pkg::OPV_SKIP_LOW);
    assign dif.is_skip_high = op_hit(dif.instr, bbc_pkg::OPM_BIT, bbc_pkg::OPV_SKIP_HIGH);
    assign dif.is_rbranch = op_hit(dif.instr, bbc_pkg::OPM_RBRANCH, bbc_pkg::OPV_RBRANCH);
    assign dif.is_wbranch = op_hit(dif.instr, bbc_pkg::OPM_WBRANCH, bbc_pkg::OPV_WBRANCH);
    assign dif.is_call = op_hit(dif.instr, bbc_pkg::OPM_CALL, bbc_pkg::OPV_CALL);
    assign dif.f_addr = dif.instr[bbc_pkg::F_LSB +: bbc_pkg::FA_W];
    assign dif.bit_idx = dif.instr[bbc_pkg::BIT_LSB +: bbc_pkg::BI_W];
    assign dif.bra_off = dif.instr[bbc_pkg::BRA_LSB +: bbc_pkg::BRA_W];
    assign dif.call_k = dif.instr[bbc_pkg::CALL_LSB +: bbc_pkg::CALL_W];
endmodule : bbc_decode
`default_nettype wire

// *** rtl/bbc_exec.sv ***
// executor for bit set/clear, bit test and skip, relative branches and call
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RULE_01 - bit clear zeroes bit b (0..7) of data register f (0..127)
// RULE_02 - bit set forces bit b of register f to one, other bits kept
// RULE_03 - relative branch goes to PC+1 plus signed 9-bit offset, two cycles
// RULE_04 - branch by W goes to PC+1 plus unsigned W, two cycles
// RULE_05 - skip-if-low discards next instruction when tested bit is 0
// RULE_06 - skip-if-high discards next instruction when tested bit is 1
// RULE_07 - call pushes PC+1 onto return stack, whole call takes two cycles
// RULE_08 - call loads 11-bit literal into PC[10:0], page latch [6:3] into PC[14:11]
// RULE_09 - none of these instructions change carry, digit carry or zero flags
module bbc_exec (
    // clock, reset, enable
    input wire logic CLK,
    input wire logic NRST,
    input wire logic CE,
    // program memory, one-cycle read latency
    output logic [14:0] PROG_ADDR,
    input wire logic [13:0] PROG_DATA,
    // core state owned elsewhere
    input wire logic [7:0] W_VAL,
    input wire logic [6:0] PAGE_LATCH,
    // data memory file
    output logic [6:0] DM_RADDR,
    input wire logic [7:0] DM_RDATA,
    output logic DM_WE,
    output logic [6:0] DM_WADDR,
    output logic [7:0] DM_WDATA,
    // return stack
    output logic STK_PUSH,
    output logic [14:0] STK_DATA,
    // status flag write strobe
    output logic FLAGS_WE
);
    bbc_dec_if dif ();
    bbc_pkg::bbc_state_t state_r;
    bbc_pkg::bbc_state_t state_nxt;
    logic [14:0] pc_r;
    logic [14:0] pc_nxt;
    logic we_r;
    logic [6:0] waddr_r;
    logic [7:0] wdata_r;
    logic push_r;
    logic [14:0] push_data_r;
    logic exec;
    logic [7:0] rd_val;
    logic bit_val;
    logic take_skip;
    logic redirect;

    function automatic logic [7:0] bit_mask(input logic [2:0] idx);
        bit_mask = 8'h01 << idx;
    endfunction : bit_mask

    function automatic logic [14:0] sext_off(input logic [8:0] off);
        sext_off = {{6{off[8]}}, off};
    endfunction : sext_off

    bbc_decode u_decode (
        .dif (dif)
    );

    assign dif.instr = PROG_DATA;
    assign exec = (state_r == bbc_pkg::BBC_ST_EXEC);

    // forward a write still in flight so back-to-back edits of one register compose
    assign rd_val = (we_r && waddr_r == dif.f_addr) ? wdata_r : DM_RDATA;
    assign bit_val = rd_val[dif.bit_idx];
    assign take_skip = exec && ((dif.is_skip_low && !bit_val) ||    // see RULE_05
                                (dif.is_skip_high && bit_val));      // see RULE_06
    assign redirect = exec && (dif.is_rbranch || dif.is_wbranch || dif.is_call);

    // pc already points past the executing word, so pc_r is PC+1
    always_comb begin
        pc_nxt = pc_r + 15'h0001;
        if (exec && dif.is_rbranch) begin
            pc_nxt = pc_r + sext_off(dif.bra_off);                  // see RULE_03
        end else if (exec && dif.is_wbranch) begin
            pc_nxt = pc_r + {7'h00, W_VAL};                          // see RULE_04
        end else if (exec && dif.is_call) begin
            pc_nxt = {PAGE_LATCH[bbc_pkg::PAGE_LSB +: bbc_pkg::PAGE_W],
                      dif.call_k};                                   // see RULE_08
        end
    end

    // fetched word after a redirect or skip is dropped: costs the second cycle
    always_comb begin
        state_nxt = bbc_pkg::BBC_ST_EXEC;
        case (state_r)
            bbc_pkg::BBC_ST_EXEC: begin
                if (redirect || take_skip) begin
                    state_nxt = bbc_pkg::BBC_ST_DISCARD;             // see RULE_03 see RULE_07
                end
            end
            bbc_pkg::BBC_ST_DISCARD: begin
                state_nxt = bbc_pkg::BBC_ST_EXEC;
            end
            default: begin
                state_nxt = bbc_pkg::BBC_ST_EXEC;
            end
        endcase
    end

    // first word after reset is not yet valid, so start by discarding
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            state_r <= bbc_pkg::BBC_ST_DISCARD;
        end else if (CE) begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            pc_r <= bbc_pkg::PC_RST;
        end else if (CE) begin
            pc_r <= pc_nxt;
        end
    end

    // read-modify-write: read now, write lands one cycle later
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            we_r <= 1'b0;
            waddr_r <= bbc_pkg::FA_RST;
            wdata_r <= bbc_pkg::DATA_RST;
        end else if (CE) begin
            we_r <= exec && (dif.is_bit_clear || dif.is_bit_set);
            waddr_r <= dif.f_addr;
            if (dif.is_bit_set) begin
                wdata_r <= rd_val | bit_mask(dif.bit_idx);            // see RULE_02
            end else begin
                wdata_r <= rd_val & ~bit_mask(dif.bit_idx);           // see RULE_01
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            push_r <= 1'b0;
            push_data_r <= bbc_pkg::PC_RST;
        end else if (CE) begin
            push_r <= exec && dif.is_call;                            // see RULE_07
            push_data_r <= pc_r;
        end
    end

    assign PROG_ADDR = pc_r;
    assign DM_RADDR = dif.f_addr;
    // strobes gated by enable so a frozen core never repeats a write or push
    assign DM_WE = we_r && CE;
    assign DM_WADDR = waddr_r;
    assign DM_WDATA = wdata_r;
    assign STK_PUSH = push_r && CE;
    assign STK_DATA = push_data_r;
    // this group never touches status flags
    assign FLAGS_WE = 1'b0;                                           // see RULE_09

    a_clear_bit: assert property (@(posedge CLK) disable iff (!NRST) // see RULE_01
        (CE && exec && dif.is_bit_clear) |=> (we_r && waddr_r == $past(dif.f_addr)
            && wdata_r == ($past(rd_val) & ~bit_mask($past(dif.bit_idx)))))
        else $error("bit clear wrote wrong value");

    a_set_bit: assert property (@(posedge CLK) disable iff (!NRST) // see RULE_02
        (CE && exec && dif.is_bit_set) |=> (we_r
            && wdata_r == ($past(rd_val) | bit_mask($past(dif.bit_idx)))))
        else $error("bit set wrote wrong value");

    a_rel_branch: assert property (@(posedge CLK) disable iff (!NRST) // see RULE_03
        (CE && exec && dif.is_rbranch) |=> (pc_r == $past(pc_r) + sext_off($past(dif.bra_off))
            && state_r == bbc_pkg::BBC_ST_DISCARD))
        else $error("relative branch target or timing wrong");

    a_w_branch: assert property (@(posedge CLK) disable iff (!NRST) // see RULE_04
        (CE && exec && dif.is_wbranch) |=> (pc_r == $past(pc_r) + {7'h00, $past(W_VAL)}
            && state_r == bbc_pkg::BBC_ST_DISCARD))
        else $error("branch by W target or timing wrong");

    a_skip_low: assert property (@(posedge CLK) disable iff (!NRST) // see RULE_05
        (CE && exec && dif.is_skip_low)
            |=> ((state_r == bbc_pkg::BBC_ST_DISCARD) == !$past(bit_val)))
        else $error("skip if low misbehaved");

    a_skip_high: assert property (@(posedge CLK) disable iff (!NRST) // see RULE_06
        (CE && exec && dif.is_skip_high)
            |=> ((state_r == bbc_pkg::BBC_ST_DISCARD) == $past(bit_val)))
        else $error("skip if high misbehaved");

    a_call_push: assert property (@(posedge CLK) disable iff (!NRST) // see RULE_07
        (CE && exec && dif.is_call) |=> (push_r && push_data_r == $past(pc_r))
            ##1 (!CE || (state_r == bbc_pkg::BBC_ST_EXEC)) [*1])
        else $error("call did not push return address");

    a_call_page: assert property (@(posedge CLK) disable iff (!NRST) // see RULE_08
        (CE && exec && dif.is_call)
            |=> (pc_r == {$past(PAGE_LATCH[6:3]), $past(dif.call_k)}))
        else $error("call target wrong");

    a_discard_once: assert property (@(posedge CLK) disable iff (!NRST)
        (CE && state_r == bbc_pkg::BBC_ST_DISCARD) |=> (state_r == bbc_pkg::BBC_ST_EXEC))
        else $error("discard lasted more than one cycle");
endmodule : bbc_exec
`default_nettype wire

// *** verif/bbc_exec_tb.sv ***
// self-checking bench for the bit, branch and call executor
`timescale 1ns/100ps
`default_nettype none
module bbc_exec_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic [13:0] prog_data = 14'h0000;
    logic [7:0] w_val = 8'h00;
    logic [6:0] page_latch = 7'h00;
    logic [7:0] dm_rdata;
    logic [14:0] prog_addr;
    logic [6:0] dm_raddr;
    logic dm_we;
    logic [6:0] dm_waddr;
    logic [7:0] dm_wdata;
    logic stk_push;
    logic [14:0] stk_data;
    logic flags_we;
    logic [13:0] pmem [0:32767];
    logic [7:0] dmem [0:127];
    logic [14:0] tr [1:16];
    logic sp [1:16];
    logic [14:0] sd [1:16];
    logic flag_ok = 1'b1;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;

    bbc_exec uut (.CLK(clk), .NRST(nrst), .CE(ce), .PROG_ADDR(prog_addr),
        .PROG_DATA(prog_data), .W_VAL(w_val), .PAGE_LATCH(page_latch),
        .DM_RADDR(dm_raddr), .DM_RDATA(dm_rdata), .DM_WE(dm_we), .DM_WADDR(dm_waddr),
        .DM_WDATA(dm_wdata), .STK_PUSH(stk_push), .STK_DATA(stk_data),
        .FLAGS_WE(flags_we));

    always #2.5 clk = ~clk;
    // data file read is combinational, as the executor expects
    assign dm_rdata = dmem[dm_raddr];
    // program memory lags one cycle behind the fetch address
    always @(posedge clk) begin
        // a frozen core must see the same word again once the enable returns
        if (ce === 1'b1) begin
            prog_data <= pmem[prog_addr];
        end
        if (dm_we === 1'b1) begin
            dmem[dm_waddr] <= dm_wdata;
        end
        flag_ok <= flag_ok & (flags_we === 1'b0);
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [13:0] bop(input logic [13:0] base, input logic [6:0] f,
                                        input logic [2:0] b);
        return base | {4'h0, b, f};
    endfunction : bop

    // memories cleared only once reset has silenced the write strobe
    task automatic hold_reset();
        nrst <= 1'b0;
        repeat (10) @(posedge clk);
        for (int i = 0; i < 32768; i++) pmem[i] = 14'h0000;
        for (int i = 0; i < 128; i++) dmem[i] = 8'h00;
    endtask : hold_reset

    task automatic go(input int n);
        nrst <= 1'b1;
        for (int i = 1; i <= n; i++) begin
            @(posedge clk);
            #1;
            tr[i] = prog_addr;
            sp[i] = stk_push;
            sd[i] = stk_data;
        end
    endtask : go

    task automatic t_bits();
        hold_reset();
        dmem[5] = 8'h10;
        dmem[127] = 8'hFF;
        pmem[0] = bop(bbc_pkg::OPV_BIT_SET, 7'h05, 3'h2);
        pmem[1] = bop(bbc_pkg::OPV_BIT_CLEAR, 7'h7F, 3'h7);
        pmem[2] = bop(bbc_pkg::OPV_BIT_SET, 7'h05, 3'h7);
        go(6);
        check("first fetch", {1'b0, tr[1]}, 16'h0001);
        check("set f5", {8'h00, dmem[5]}, 16'h0094);
        check("clear f127", {8'h00, dmem[127]}, 16'h007F);
    endtask : t_bits

    task automatic t_rbranch();
        hold_reset();
        pmem[0] = bbc_pkg::OPV_RBRANCH | 14'h0009;
        pmem[1] = bop(bbc_pkg::OPV_BIT_SET, 7'h03, 3'h0);
        pmem[10] = bbc_pkg::OPV_RBRANCH | 14'h0100;
        pmem[11] = bop(bbc_pkg::OPV_BIT_SET, 7'h03, 3'h1);
        go(6);
        check("rbranch fwd", {1'b0, tr[2]}, 16'h000A);
        check("rbranch next", {1'b0, tr[3]}, 16'h000B);
        check("rbranch back", {1'b0, tr[4]}, 16'h7F0B);
        check("rbranch discard", {8'h00, dmem[3]}, 16'h0000);
    endtask : t_rbranch

    task automatic t_wbranch();
        hold_reset();
        w_val <= 8'hFF;
        pmem[0] = bbc_pkg::OPV_WBRANCH;
        pmem[1] = bop(bbc_pkg::OPV_BIT_SET, 7'h03, 3'h0);
        go(4);
        check("wbranch target", {1'b0, tr[2]}, 16'h0100);
        check("wbranch next", {1'b0, tr[3]}, 16'h0101);
        check("wbranch discard", {8'h00, dmem[3]}, 16'h0000);
    endtask : t_wbranch

    // each skip form both taken and not taken
    task automatic t_skip();
        hold_reset();
        dmem[8] = 8'h80;
        pmem[0] = bop(bbc_pkg::OPV_SKIP_LOW, 7'h06, 3'h1);
        pmem[1] = bop(bbc_pkg::OPV_BIT_SET, 7'h07, 3'h0);
        pmem[2] = bop(bbc_pkg::OPV_SKIP_HIGH, 7'h06, 3'h1);
        pmem[3] = bop(bbc_pkg::OPV_BIT_SET, 7'h07, 3'h1);
        pmem[4] = bop(bbc_pkg::OPV_SKIP_HIGH, 7'h08, 3'h7);
        pmem[5] = bop(bbc_pkg::OPV_BIT_SET, 7'h07, 3'h2);
        pmem[6] = bop(bbc_pkg::OPV_SKIP_LOW, 7'h08, 3'h7);
        pmem[7] = bop(bbc_pkg::OPV_BIT_SET, 7'h07, 3'h3);
        go(10);
        check("skip result", {8'h00, dmem[7]}, 16'h000A);
    endtask : t_skip

    task automatic t_call();
        hold_reset();
        page_latch <= 7'h55;
        pmem[0] = bbc_pkg::OPV_CALL | 14'h07FF;
        pmem[1] = bop(bbc_pkg::OPV_BIT_SET, 7'h03, 3'h0);
        go(4);
        check("push early", {15'h0000, sp[1]}, 16'h0000);
        check("push", {15'h0000, sp[2]}, 16'h0001);
        check("return addr", {1'b0, sd[2]}, 16'h0001);
        check("push once", {15'h0000, sp[3]}, 16'h0000);
        check("call target", {1'b0, tr[2]}, 16'h57FF);
        check("call next", {1'b0, tr[3]}, 16'h5800);
        check("call discard", {8'h00, dmem[3]}, 16'h0000);
    endtask : t_call

    // enable dropped with a write in flight: nothing may land or advance
    task automatic t_freeze();
        hold_reset();
        pmem[0] = bop(bbc_pkg::OPV_BIT_SET, 7'h03, 3'h0);
        pmem[1] = bop(bbc_pkg::OPV_BIT_SET, 7'h03, 3'h1);
        go(1);
        @(posedge clk);
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("frozen pc", {1'b0, prog_addr}, 16'h0002);
        check("frozen write", {15'h0000, dm_we}, 16'h0000);
        check("frozen data", {8'h00, dmem[3]}, 16'h0000);
        @(posedge clk);
        ce <= 1'b1;
        go(4);
        check("thawed data", {8'h00, dmem[3]}, 16'h0003);
    endtask : t_freeze

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        t_bits();
        t_rbranch();
        t_wbranch();
        t_skip();
        t_call();
        t_freeze();
        check("flags untouched", {15'h0000, flag_ok}, 16'h0001);
        end_of_test();
    end
endmodule : bbc_exec_tb
`default_nettype wire
